/* rtl/dma_channel_control.sv */
// dma channel control: per-channel control registers, arbitration and
// interrupt status behind an axi4-lite slave
// assumes start, abort, engine_busy and block_done come from logic on clk
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [RULE1] channel_active reads on or engine still busy
// [RULE2] chain_direction picks which neighbour's completion enables
// [RULE3] direction matters only while chain_allow set
// [RULE4] channel_on enables, clearing disables
// [RULE5] accept_events_when_off lets events register while off
// [RULE6] chain_allow gates all chaining
// [RULE7] without auto_rearm, completion clears channel_on
// [RULE8] event_seen set by a registered event
// [RULE9] channel_priority value is arbitration priority
// [RULE10] active held until current transaction ends
// [RULE11] unimplemented bits ignore writes, read zero
// [RULE12] highest priority wins, ties to lowest index
module dma_channel_control #(
  parameter int unsigned NUM_CH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dma_ctrl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [dma_ctrl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // channel events
  input wire logic [NUM_CH-1:0] start_evt,
  input wire logic [NUM_CH-1:0] abort_evt,
  // data engine
  output logic [NUM_CH-1:0] grant,
  input wire logic engine_busy,
  input wire logic [NUM_CH-1:0] block_done,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    dma_ctrl_pkg::wr_state_t wr_st;
    dma_ctrl_pkg::rd_state_t rd_st;
    logic aw_got;
    logic w_got;
    logic [dma_ctrl_pkg::ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] irq_stat;
    logic [31:0] irq_mask;
    logic [NUM_CH-1:0] grant;
    logic irq;
  } top_st_t;

  top_st_t st_r;
  top_st_t st_nxt;

  // per-channel wiring
  logic [31:0] ctrl_rd [NUM_CH];
  logic [NUM_CH-1:0] ch_req;
  logic [NUM_CH-1:0] ch_abort;
  logic [NUM_CH-1:0] wr_sel;
  logic [NUM_CH-1:0] wr_lo;
  logic [NUM_CH-1:0] wr_hi;
  logic [2*NUM_CH-1:0] ch_prio;
  logic [NUM_CH-1:0] arb_grant;
  dma_ctrl_pkg::chan_in_t cin [NUM_CH];

  // write-path decode
  logic wr_exec;
  logic wr_stat;
  logic wr_mask;
  logic wr_hit;
  logic [31:0] wr_bytes;

  // read-path decode
  logic [31:0] rd_val;
  logic rd_hit;

  // interrupt events
  logic [31:0] irq_set;
  logic [31:0] irq_impl;

  ////////////////////////////////////////////////////////////////////////////
  // channels

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [7:0] CH_OFS =
        dma_ctrl_pkg::CTRL_BASE_OFS + 8'(4 * i);

    assign wr_sel[i] = (st_r.awaddr == CH_OFS);
    assign wr_lo[i] = wr_exec & wr_sel[i] & st_r.wstrb[0];
    assign wr_hi[i] = wr_exec & wr_sel[i] & st_r.wstrb[1];

    assign cin[i].start = start_evt[i];
    assign cin[i].abort = abort_evt[i];
    assign cin[i].done = block_done[i];
    // engine busy on this channel keeps its active bit up
    assign cin[i].txn_busy = engine_busy & st_r.grant[i]; // [RULE10]

    // the end channels have no neighbour on one side: tie that input off
    if (i > 0) begin : g_lo
      assign cin[i].done_from_lower_idx = block_done[i-1];
    end else begin : g_lo0
      assign cin[i].done_from_lower_idx = 1'b0;
    end
    if (i < NUM_CH - 1) begin : g_hi
      assign cin[i].done_from_higher_idx = block_done[i+1];
    end else begin : g_hin
      assign cin[i].done_from_higher_idx = 1'b0;
    end

    assign ch_prio[2*i +: 2] =
        ctrl_rd[i][dma_ctrl_pkg::PRIO_LSB +: dma_ctrl_pkg::PRIO_W];

    chan_state u_chan (
      .clk(clk),
      .rst(rst),
      .wr_lo(wr_lo[i]),
      .wr_hi(wr_hi[i]),
      .wdata(st_r.wdata[15:0]),
      .cin(cin[i]),
      .ctrl_rd(ctrl_rd[i]),
      .req(ch_req[i]),
      .abort_taken(ch_abort[i])
    );
  end

  prio_arbiter #(
    .N(NUM_CH)
  ) u_arb (
    .req(ch_req),
    .prio(ch_prio),
    .grant(arb_grant)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // an address that maps to nothing still completes, with SLVERR, so a
  // stray access never hangs the master; the protection bits are taken
  // but not checked, every register is open to any master

  assign wr_exec = (st_r.wr_st == dma_ctrl_pkg::WR_COLLECT) &
                   st_r.aw_got & st_r.w_got;
  assign wr_stat = (st_r.awaddr == dma_ctrl_pkg::IRQ_STAT_OFS);
  assign wr_mask = (st_r.awaddr == dma_ctrl_pkg::IRQ_MASK_OFS);
  assign wr_hit = wr_stat | wr_mask | (|wr_sel);

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_bytes[8*b +: 8] = {8{st_r.wstrb[b]}};
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (s_axi_araddr == dma_ctrl_pkg::CTRL_BASE_OFS + 8'(4 * i)) begin
        rd_val = ctrl_rd[i];
        rd_hit = 1'b1;
      end
    end
    if (s_axi_araddr == dma_ctrl_pkg::IRQ_STAT_OFS) begin
      rd_val = st_r.irq_stat;
      rd_hit = 1'b1;
    end
    if (s_axi_araddr == dma_ctrl_pkg::IRQ_MASK_OFS) begin
      rd_val = st_r.irq_mask;
      rd_hit = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt sources: one done bit and one abort bit per channel
  // only implemented bits can be masked on, so no dead bit holds irq up

  always_comb begin
    irq_set = 32'h0000_0000;
    irq_impl = 32'h0000_0000;
    for (int i = 0; i < NUM_CH; i++) begin
      irq_set[dma_ctrl_pkg::IRQ_DONE_LSB + i] = block_done[i];
      irq_set[dma_ctrl_pkg::IRQ_ABORT_LSB + i] = ch_abort[i];
      irq_impl[dma_ctrl_pkg::IRQ_DONE_LSB + i] = 1'b1;
      irq_impl[dma_ctrl_pkg::IRQ_ABORT_LSB + i] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;

    // write channel: address and data may arrive in either order
    // the write then runs from the captured copy one cycle later, which
    // keeps the register update off the bus inputs' timing path
    case (st_r.wr_st)
      dma_ctrl_pkg::WR_COLLECT: begin
        if (s_axi_awvalid && !st_r.aw_got) begin
          st_nxt.aw_got = 1'b1;
          st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_got) begin
          st_nxt.w_got = 1'b1;
          st_nxt.wdata = s_axi_wdata;
          st_nxt.wstrb = s_axi_wstrb;
        end
        if (wr_exec) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.bresp = wr_hit ? dma_ctrl_pkg::RESP_OKAY
                                : dma_ctrl_pkg::RESP_SLVERR;
          st_nxt.wr_st = dma_ctrl_pkg::WR_RESP;
        end
      end
      dma_ctrl_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          st_nxt.wr_st = dma_ctrl_pkg::WR_COLLECT;
        end
      end
      default: begin
        st_nxt.wr_st = dma_ctrl_pkg::WR_COLLECT;
      end
    endcase

    // read channel: data registered one cycle after the address; the
    // channel bits are taken at the handshake edge, so a read racing a
    // hardware update returns the value from before it
    case (st_r.rd_st)
      dma_ctrl_pkg::RD_IDLE: begin
        if (s_axi_arvalid) begin
          st_nxt.rdata = rd_val;
          st_nxt.rresp = rd_hit ? dma_ctrl_pkg::RESP_OKAY
                                : dma_ctrl_pkg::RESP_SLVERR;
          st_nxt.rd_st = dma_ctrl_pkg::RD_RESP;
        end
      end
      dma_ctrl_pkg::RD_RESP: begin
        if (s_axi_rready) begin
          st_nxt.rd_st = dma_ctrl_pkg::RD_IDLE;
        end
      end
      default: begin
        st_nxt.rd_st = dma_ctrl_pkg::RD_IDLE;
      end
    endcase

    // mask: only bits with a source behind them are writable
    if (wr_exec && wr_mask) begin
      st_nxt.irq_mask = (st_r.irq_mask & ~wr_bytes) |
                        (st_r.wdata & wr_bytes & irq_impl);
    end

    // status: write one to clear, a new event in the same cycle wins
    if (wr_exec && wr_stat) begin
      st_nxt.irq_stat = st_r.irq_stat & ~(st_r.wdata & wr_bytes);
    end
    st_nxt.irq_stat = st_nxt.irq_stat | irq_set;

    // the grant only moves between transactions, so clearing channel_on
    // mid-transfer lets the engine finish its beat first
    if (!engine_busy) begin
      st_nxt.grant = arb_grant; // [RULE10]
    end

    // irq is a flop fed from the next status and mask, so it moves on the
    // same edge as the bits behind it and never glitches on the pin
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{
        wr_st: dma_ctrl_pkg::WR_COLLECT,
        rd_st: dma_ctrl_pkg::RD_IDLE,
        aw_got: 1'b0,
        w_got: 1'b0,
        awaddr: '0,
        wdata: 32'h0000_0000,
        wstrb: 4'h0,
        bresp: dma_ctrl_pkg::RESP_OKAY,
        rdata: 32'h0000_0000,
        rresp: dma_ctrl_pkg::RESP_OKAY,
        irq_stat: dma_ctrl_pkg::IRQ_RESET,
        irq_mask: dma_ctrl_pkg::IRQ_RESET,
        grant: '0,
        irq: 1'b0
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // the readys are decoded from state, so a capture drops them at once
  // and no second beat can slip in behind it

  assign s_axi_awready = (st_r.wr_st == dma_ctrl_pkg::WR_COLLECT) &
                         ~st_r.aw_got;
  assign s_axi_wready = (st_r.wr_st == dma_ctrl_pkg::WR_COLLECT) &
                        ~st_r.w_got;
  assign s_axi_bvalid = (st_r.wr_st == dma_ctrl_pkg::WR_RESP);
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = (st_r.rd_st == dma_ctrl_pkg::RD_IDLE);
  assign s_axi_rvalid = (st_r.rd_st == dma_ctrl_pkg::RD_RESP);
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign grant = st_r.grant;
  assign irq = st_r.irq;

endmodule : dma_channel_control
`default_nettype wire

/* rtl/dma_ctrl_pkg.sv */
// constants, field layout and carrier types for the dma channel control
// assumes a 32-bit axi4-lite slave and up to eight channels
package dma_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] CTRL_BASE_OFS = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h40;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h44;
  localparam int unsigned MAX_CH = 8;

  ////////////////////////////////////////////////////////////////////////////
  // channel_control field positions
  localparam int unsigned BIT_ACTIVE = 15;
  localparam int unsigned BIT_CHAIN_DIR = 8;
  localparam int unsigned BIT_ON = 7;
  localparam int unsigned BIT_ACCEPT_OFF = 6;
  localparam int unsigned BIT_CHAIN_ALLOW = 5;
  localparam int unsigned BIT_AUTO_REARM = 4;
  localparam int unsigned BIT_EVENT_SEEN = 2;
  localparam int unsigned PRIO_LSB = 0;
  localparam int unsigned PRIO_W = 2;

  // interrupt layout: done events in the low byte, aborts in the next
  localparam int unsigned IRQ_DONE_LSB = 0;
  localparam int unsigned IRQ_ABORT_LSB = 8;
  localparam logic [31:0] IRQ_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic chain_dir;
    logic on;
    logic accept_off;
    logic chain_allow;
    logic auto_rearm;
    logic [PRIO_W-1:0] prio;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 7'h00;

  typedef struct packed {
    logic start;
    logic abort;
    logic done;
    logic done_from_lower_idx;
    logic done_from_higher_idx;
    logic txn_busy;
  } chan_in_t;

  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } wr_state_t;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RESP = 1'b1
  } rd_state_t;

endpackage : dma_ctrl_pkg

/* rtl/chan_state.sv */
// one channel's control bits and its pending event
// assumes event and engine inputs are on clk already
`timescale 1ns/1ps
`default_nettype none
module chan_state (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // software write, byte lanes 0 and 1
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [15:0] wdata,
  // hardware events
  input wire dma_ctrl_pkg::chan_in_t cin,
  // outputs
  output logic [31:0] ctrl_rd,
  output logic req,
  output logic abort_taken
);

  typedef struct packed {
    dma_ctrl_pkg::ctrl_t ctrl;
    logic seen;
  } chan_st_t;

  chan_st_t st_r;
  chan_st_t st_nxt;
  logic accept;
  logic chain_hit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    accept = st_r.ctrl.on | st_r.ctrl.accept_off; // [RULE5]
    chain_hit = st_r.ctrl.chain_allow & (st_r.ctrl.chain_dir ? // [RULE3]
        cin.done_from_higher_idx : cin.done_from_lower_idx); // [RULE2]
    abort_taken = cin.abort & accept;
    if (wr_lo) begin
      st_nxt.ctrl.on = wdata[dma_ctrl_pkg::BIT_ON]; // [RULE4]
      st_nxt.ctrl.accept_off = wdata[dma_ctrl_pkg::BIT_ACCEPT_OFF];
      st_nxt.ctrl.chain_allow = wdata[dma_ctrl_pkg::BIT_CHAIN_ALLOW];
      st_nxt.ctrl.auto_rearm = wdata[dma_ctrl_pkg::BIT_AUTO_REARM];
      st_nxt.ctrl.prio = wdata[dma_ctrl_pkg::PRIO_LSB +:
                               dma_ctrl_pkg::PRIO_W];
    end
    if (wr_hi) begin
      st_nxt.ctrl.chain_dir = wdata[dma_ctrl_pkg::BIT_CHAIN_DIR];
    end
    // hardware beats a software write landing in the same cycle
    if (cin.done && !st_r.ctrl.auto_rearm) begin
      st_nxt.ctrl.on = 1'b0; // [RULE7]
    end
    if (chain_hit) begin
      st_nxt.ctrl.on = 1'b1; // [RULE6]
    end
    if (cin.done || abort_taken) begin
      st_nxt.seen = 1'b0;
    end
    // a start in the clearing cycle is kept: set wins
    if (cin.start && accept) begin
      st_nxt.seen = 1'b1; // [RULE8]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{ctrl: dma_ctrl_pkg::CTRL_RESET, seen: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign req = st_r.ctrl.on & st_r.seen;

  always_comb begin
    ctrl_rd = 32'h0000_0000; // [RULE11]
    // busy stays up while the engine finishes a granted beat
    ctrl_rd[dma_ctrl_pkg::BIT_ACTIVE] = st_r.ctrl.on | cin.txn_busy; // [RULE1]
    ctrl_rd[dma_ctrl_pkg::BIT_CHAIN_DIR] = st_r.ctrl.chain_dir;
    ctrl_rd[dma_ctrl_pkg::BIT_ON] = st_r.ctrl.on;
    ctrl_rd[dma_ctrl_pkg::BIT_ACCEPT_OFF] = st_r.ctrl.accept_off;
    ctrl_rd[dma_ctrl_pkg::BIT_CHAIN_ALLOW] = st_r.ctrl.chain_allow;
    ctrl_rd[dma_ctrl_pkg::BIT_AUTO_REARM] = st_r.ctrl.auto_rearm;
    ctrl_rd[dma_ctrl_pkg::BIT_EVENT_SEEN] = st_r.seen;
    ctrl_rd[dma_ctrl_pkg::PRIO_LSB +: dma_ctrl_pkg::PRIO_W] = st_r.ctrl.prio;
  end

endmodule : chan_state
`default_nettype wire

/* rtl/prio_arbiter.sv */
// combinational priority arbiter, one-hot grant
// assumes the caller registers the grant
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter #(
  parameter int unsigned N = 4
) (
  // requests
  input wire logic [N-1:0] req,
  input wire logic [2*N-1:0] prio,
  // result
  output logic [N-1:0] grant
);

  logic found;
  logic [1:0] best;

  // scan high index to low so a tie lands on the lowest index
  always_comb begin
    found = 1'b0;
    best = 2'h0;
    grant = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && (!found || prio[2*i +: 2] >= best)) begin
        found = 1'b1;
        best = prio[2*i +: 2]; // [RULE9]
        grant = '0;
        grant[i] = 1'b1; // [RULE12]
      end
    end
  end

endmodule : prio_arbiter
`default_nettype wire

/* tb/dma_ctrl_sva.sv */
// concurrent checks on the channel control block's bus and engine ports
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_sva #(
  parameter int unsigned NUM_CH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // engine and interrupt
  input wire logic [NUM_CH-1:0] grant,
  input wire logic engine_busy,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // reset is checked with the disable overridden, it is the antecedent
  reset_idle_a: assert property (disable iff (1'b0)
    rst |=> !s_axi_bvalid && !s_axi_rvalid && grant == '0 && !irq)
    else $error("outputs not idle after reset");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> !s_axi_bvalid ##2 s_axi_bvalid)
    else $error("write response not two cycles after request");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken during response");
  wr_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during read data");
  grant_onehot_a: assert property ($onehot0(grant))
    else $error("more than one channel granted");
  grant_hold_a: assert property (engine_busy |=> $stable(grant))
    else $error("grant moved during a transaction");
endmodule : dma_ctrl_sva

bind dma_channel_control dma_ctrl_sva #(.NUM_CH(NUM_CH)) chk (.clk, .rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .grant, .engine_busy, .irq);
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the dma channel control block
// assumes four channels, a 50 ns clock and a single axi4-lite master here
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, engine_busy;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, start_evt, abort_evt, block_done, grant;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;

  dma_channel_control #(.NUM_CH(4)) dut (.clk, .rst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .start_evt, .abort_evt, .grant, .engine_busy, .block_done, .irq);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // a hung handshake ends here rather than running forever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] eb = dma_ctrl_pkg::RESP_OKAY);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, eb});
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
      input logic [1:0] er = dma_ctrl_pkg::RESP_OKAY);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    check("rdata", s_axi_rdata, exp);
    check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask : rd

  // one-cycle pulses on the event and completion inputs
  task automatic ev(input logic [3:0] st, ab, dn);
    @(posedge clk);
    start_evt <= st;
    abort_evt <= ab;
    block_done <= dn;
    @(posedge clk);
    start_evt <= 4'h0;
    abort_evt <= 4'h0;
    block_done <= 4'h0;
  endtask : ev

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reg();
    do_reset();
    wr(8'h80, 32'hffff_ffff, dma_ctrl_pkg::RESP_SLVERR);
    rd(8'h00, 32'h0);
    rd(8'h80, 32'h0, dma_ctrl_pkg::RESP_SLVERR);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'h0000_81f3);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
  endtask : s_reg

  task automatic s_accept();
    do_reset();
    ev(4'h2, 4'h2, 4'h0);
    rd(8'h04, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h04, 32'h0000_0040);
    ev(4'h2, 4'h0, 4'h0);
    rd(8'h04, 32'h0000_0044);
    ev(4'h0, 4'h2, 4'h0);
    rd(8'h04, 32'h0000_0040);
    rd(8'h40, 32'h0000_0200);
  endtask : s_accept

  // disabling mid-transaction: active must stay up until the engine lets go
  task automatic s_xfer();
    do_reset();
    wr(8'h00, 32'h0000_0080);
    ev(4'h1, 4'h0, 4'h0);
    repeat (2) @(posedge clk);
    #1 check("grant", {28'h0, grant}, 32'h1);
    @(posedge clk);
    engine_busy <= 1'b1;
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0000_8004);
    ev(4'h0, 4'h0, 4'h1);
    @(posedge clk);
    engine_busy <= 1'b0;
    rd(8'h00, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    wr(8'h44, 32'h1);
    check("irq", {31'h0, irq}, 32'h1);
    wr(8'h40, 32'h1);
    check("irq", {31'h0, irq}, 32'h0);
  endtask : s_xfer

  task automatic s_rearm();
    for (int i = 0; i < 2; i++) begin
      do_reset();
      wr(8'h08, (i == 1) ? 32'h90 : 32'h80);
      ev(4'h4, 4'h0, 4'h0);
      ev(4'h0, 4'h0, 4'h4);
      rd(8'h08, (i == 1) ? 32'h8090 : 32'h0);
    end
  endtask : s_rearm

  // bit 1 of i is the direction, bit 0 allows chaining
  task automatic s_chain();
    for (int i = 0; i < 4; i++) begin
      logic [31:0] cfg;
      do_reset();
      cfg = {23'h0, i[1], 2'h0, i[0], 5'h0};
      wr(8'h04, cfg);
      ev(4'h0, 4'h0, i[1] ? 4'h1 : 4'h4);
      rd(8'h04, cfg);
      ev(4'h0, 4'h0, i[1] ? 4'h4 : 4'h1);
      rd(8'h04, i[0] ? (cfg | 32'h8080) : cfg);
    end
  endtask : s_chain

  // last pass is a tie, which the lower channel must win
  task automatic s_prio();
    for (int i = 0; i < 5; i++) begin
      logic [1:0] lo, hi;
      do_reset();
      lo = (i < 4) ? 2'(i) : 2'h2;
      hi = (i < 4) ? 2'(3 - i) : 2'h2;
      wr(8'h04, {24'h0, 6'h20, lo});
      wr(8'h0c, {24'h0, 6'h20, hi});
      ev(4'ha, 4'h0, 4'h0);
      repeat (2) @(posedge clk);
      #1 check("grant", {28'h0, grant}, (hi > lo) ? 32'h8 : 32'h2);
    end
  endtask : s_prio

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, engine_busy} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awprot, s_axi_arprot} = 6'h0;
    s_axi_wstrb = 4'hf;
    {start_evt, abort_evt, block_done} = 12'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    s_reg();
    s_accept();
    s_xfer();
    s_rearm();
    s_chain();
    s_prio();
    summarize();
  end
endmodule : tb
`default_nettype wire
